// ---- design/span_display_pkg.sv ----
package span_display_pkg;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_US       = 1000;
   localparam int TICK_CYCLES   = (TICK_US * 1000) / CLK_PERIOD_NS;
   localparam int BLINK_HALF_MS = 250;
   localparam int SPIN_STEP_MS  = 100;

   // ------------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------------
   localparam int NUM_SPANS   = 16;
   localparam int GROUP_SPANS = 4;
   localparam int NUM_GROUPS  = NUM_SPANS / GROUP_SPANS;
   localparam int COLS        = 5;
   localparam int ROWS        = 7;
   localparam int GLYPH_BITS  = COLS * (ROWS - 1);
   localparam int DOTS        = COLS * ROWS;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [15:0] IDLE_RESET  = 16'hffff;
   localparam logic [15:0] TICK_RESET  = 16'h0000;
   localparam logic [7:0]  BLINK_RESET = 8'h00;
   localparam logic [6:0]  SPIN_RESET  = 7'h00;

   typedef enum logic [3:0] {
      GLYPH_BLANK,
      GLYPH_BLUE,
      GLYPH_E1,
      GLYPH_FRAME,
      GLYPH_MAINT,
      GLYPH_NO_IO,
      GLYPH_OOS,
      GLYPH_RED,
      GLYPH_T1,
      GLYPH_YELLOW,
      GLYPH_SPIN0,
      GLYPH_SPIN1,
      GLYPH_SPIN2,
      GLYPH_SPIN3
   } glyph_t;

endpackage

// ---- design/span_glyph_rom.sv ----
`timescale 1ns/100ps
module span_glyph_rom (
   input  wire logic                                   i_core_clk,
   input  wire logic                                   i_reset_n,
   input  wire span_display_pkg::glyph_t               i_glyph,
   output logic [span_display_pkg::GLYPH_BITS-1:0]     o_rows
);
   import span_display_pkg::*;

   // ------------------------------------------------------------------
   // top six rows, row 0 in the high bits, column 0 in each row's msb
   // ------------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         o_rows <= '0;
      end else begin
         unique case (i_glyph)
            GLYPH_BLANK:  o_rows <= {5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
            GLYPH_BLUE:   o_rows <= {5'h1e, 5'h11, 5'h1e, 5'h11, 5'h11, 5'h1e};
            GLYPH_E1:     o_rows <= {5'h1d, 5'h13, 5'h19, 5'h11, 5'h11, 5'h1d};
            GLYPH_FRAME:  o_rows <= {5'h1f, 5'h10, 5'h1e, 5'h10, 5'h10, 5'h10};
            GLYPH_MAINT:  o_rows <= {5'h11, 5'h1b, 5'h15, 5'h11, 5'h11, 5'h11};
            GLYPH_NO_IO:  o_rows <= {5'h11, 5'h19, 5'h15, 5'h13, 5'h11, 5'h11};
            GLYPH_OOS:    o_rows <= {5'h0e, 5'h11, 5'h11, 5'h11, 5'h11, 5'h0e};
            GLYPH_RED:    o_rows <= {5'h1e, 5'h11, 5'h1e, 5'h14, 5'h12, 5'h11};
            GLYPH_T1:     o_rows <= {5'h1d, 5'h0b, 5'h09, 5'h09, 5'h09, 5'h09};
            GLYPH_YELLOW: o_rows <= {5'h11, 5'h11, 5'h0a, 5'h04, 5'h04, 5'h04};
            // rotating bar for the download meter
            GLYPH_SPIN0:  o_rows <= {5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04};
            GLYPH_SPIN1:  o_rows <= {5'h01, 5'h02, 5'h04, 5'h04, 5'h08, 5'h10};
            GLYPH_SPIN2:  o_rows <= {5'h00, 5'h00, 5'h1f, 5'h00, 5'h00, 5'h00};
            GLYPH_SPIN3:  o_rows <= {5'h10, 5'h08, 5'h04, 5'h04, 5'h02, 5'h01};
            default:      o_rows <= '0;
         endcase
      end
   end

endmodule

// ---- design/span_alarm_status_display.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - status shown on a five column by seven row dot matrix
// - each state has its own character pattern, except slips, out of frame and signaling errors, which share one
// - download in progress shows a rotating line pattern
// - only the most severe active condition is shown
// - bottom row dots mark reporting span groups, leftmost is group 1
// - rightmost bottom dot blinks while the processor runs
// - loss of carrier is a major alarm
// - slips, out of frame, remote carrier, signaling, out of service are minor
// - card failure lamp lights on any card or module circuit fault
// - spans are grouped in fours and reported per group
module span_alarm_status_display #(
   parameter int TICK_CYCLES = span_display_pkg::TICK_CYCLES
) (
   input  wire logic                                 i_core_clk,
   input  wire logic                                 i_reset_n,
   input  wire logic [span_display_pkg::NUM_SPANS-1:0] i_loss_of_carrier,
   input  wire logic [span_display_pkg::NUM_SPANS-1:0] i_loss_remote_carrier,
   input  wire logic [span_display_pkg::NUM_SPANS-1:0] i_blue_alarm,
   input  wire logic [span_display_pkg::NUM_SPANS-1:0] i_slip_threshold,
   input  wire logic [span_display_pkg::NUM_SPANS-1:0] i_out_of_frame_threshold,
   input  wire logic [span_display_pkg::NUM_SPANS-1:0] i_out_of_frame,
   input  wire logic [span_display_pkg::NUM_SPANS-1:0] i_signaling_bit_error,
   input  wire logic [span_display_pkg::NUM_SPANS-1:0] i_out_of_service_state,
   input  wire logic                                 i_card_is_e1,
   input  wire logic                                 i_maintenance,
   input  wire logic                                 i_io_module_present,
   input  wire logic                                 i_download_active,
   input  wire logic                                 i_heartbeat,
   input  wire logic [15:0]                          i_hb_timeout_ms,
   input  wire logic                                 i_card_circuit_fault,
   input  wire logic                                 i_io_circuit_fault,
   output logic [span_display_pkg::DOTS-1:0]         o_dots,
   output logic                                      o_card_fail_lamp,
   output logic                                      o_major_alarm,
   output logic                                      o_minor_alarm,
   output logic                                      o_cpu_alive
);
   import span_display_pkg::*;

   // ------------------------------------------------------------------
   // per group reduction
   // ------------------------------------------------------------------
   function automatic logic [NUM_GROUPS-1:0] group_any(input logic [NUM_SPANS-1:0] s);
      logic [NUM_GROUPS-1:0] g;
      g = '0;
      for (int k = 0; k < NUM_GROUPS; k++) begin
         g[k] = |s[k*GROUP_SPANS +: GROUP_SPANS];
      end
      return g;
   endfunction

   logic [NUM_GROUPS-1:0] carrier_grp;
   logic [NUM_GROUPS-1:0] remote_grp;
   logic [NUM_GROUPS-1:0] blue_grp;
   logic [NUM_GROUPS-1:0] frame_grp;
   logic [NUM_GROUPS-1:0] oos_grp;
   logic                  major_now;
   logic                  minor_now;

   assign carrier_grp = group_any(i_loss_of_carrier);
   assign remote_grp  = group_any(i_loss_remote_carrier);
   assign blue_grp    = group_any(i_blue_alarm);
   // slips and signaling errors share the framing character
   assign frame_grp   = group_any(i_slip_threshold | i_out_of_frame_threshold
                                  | i_out_of_frame | i_signaling_bit_error);
   assign oos_grp     = group_any(i_out_of_service_state);
   assign major_now   = |carrier_grp;
   assign minor_now   = |{remote_grp, blue_grp, frame_grp, oos_grp};

   // ------------------------------------------------------------------
   // severity pick
   // ------------------------------------------------------------------
   glyph_t                sel_d;
   glyph_t                sel_q;
   logic [NUM_GROUPS-1:0] mask_d;
   logic [NUM_GROUPS-1:0] mask_q;
   logic [1:0]            spin_phase_q;

   always_comb begin
      sel_d  = GLYPH_BLANK;
      mask_d = '0;
      if (i_download_active) begin
         sel_d = glyph_t'(4'(GLYPH_SPIN0) + 4'(spin_phase_q));
      end else if (!i_io_module_present) begin
         sel_d = GLYPH_NO_IO;
      end else if (major_now) begin
         sel_d  = GLYPH_RED;
         mask_d = carrier_grp;
      end else if (|remote_grp) begin
         sel_d  = GLYPH_YELLOW;
         mask_d = remote_grp;
      end else if (|blue_grp) begin
         sel_d  = GLYPH_BLUE;
         mask_d = blue_grp;
      end else if (|frame_grp) begin
         sel_d  = GLYPH_FRAME;
         mask_d = frame_grp;
      end else if (|oos_grp) begin
         sel_d  = GLYPH_OOS;
         mask_d = oos_grp;
      end else if (i_maintenance) begin
         sel_d = GLYPH_MAINT;
      end else if (i_card_is_e1) begin
         sel_d = GLYPH_E1;
      end else begin
         sel_d = GLYPH_T1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         sel_q  <= GLYPH_BLANK;
         mask_q <= '0;
      end else begin
         sel_q  <= sel_d;
         mask_q <= mask_d;
      end
   end

   // ------------------------------------------------------------------
   // millisecond tick, download meter step
   // ------------------------------------------------------------------
   logic [15:0] tick_cnt_q;
   logic        tick_q;
   logic [6:0]  spin_cnt_q;

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         tick_cnt_q <= TICK_RESET;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == 16'(TICK_CYCLES - 1)) begin
         tick_cnt_q <= TICK_RESET;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 16'h0001;
         tick_q     <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         spin_cnt_q   <= SPIN_RESET;
         spin_phase_q <= 2'h0;
      end else if (!i_download_active) begin
         // meter always restarts from the upright bar
         spin_cnt_q   <= SPIN_RESET;
         spin_phase_q <= 2'h0;
      end else if (tick_q) begin
         if (spin_cnt_q == 7'(SPIN_STEP_MS - 1)) begin
            spin_cnt_q   <= SPIN_RESET;
            spin_phase_q <= spin_phase_q + 2'h1;
         end else begin
            spin_cnt_q <= spin_cnt_q + 7'h01;
         end
      end
   end

   // ------------------------------------------------------------------
   // processor heartbeat
   // ------------------------------------------------------------------
   logic [15:0] idle_ms_q;
   logic        alive_q;
   logic [7:0]  blink_cnt_q;
   logic        blink_q;

   // idle starts saturated so the dot never blinks before the first beat
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         idle_ms_q <= IDLE_RESET;
      end else if (i_heartbeat) begin
         idle_ms_q <= 16'h0000;
      end else if (tick_q && idle_ms_q != IDLE_RESET) begin
         idle_ms_q <= idle_ms_q + 16'h0001;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         alive_q <= 1'b0;
      end else begin
         alive_q <= i_heartbeat ? (i_hb_timeout_ms != 16'h0000)
                                : (idle_ms_q < i_hb_timeout_ms);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         blink_cnt_q <= BLINK_RESET;
         blink_q     <= 1'b0;
      end else if (!alive_q) begin
         blink_cnt_q <= BLINK_RESET;
         blink_q     <= 1'b0;
      end else if (tick_q) begin
         if (blink_cnt_q == 8'(BLINK_HALF_MS - 1)) begin
            blink_cnt_q <= BLINK_RESET;
            blink_q     <= ~blink_q;
         end else begin
            blink_cnt_q <= blink_cnt_q + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------------
   // matrix and lamps
   // ------------------------------------------------------------------
   logic [GLYPH_BITS-1:0] glyph_rows;
   logic [COLS-1:0]       bottom_q;

   span_glyph_rom u_rom (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .i_glyph    (sel_q),
      .o_rows     (glyph_rows)
   );

   // bottom row lines up with the rom's registered output
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         bottom_q <= '0;
      end else begin
         bottom_q <= {mask_q[0], mask_q[1], mask_q[2], mask_q[3], blink_q};
      end
   end

   assign o_dots      = {glyph_rows, bottom_q};
   assign o_cpu_alive = alive_q;

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         o_card_fail_lamp <= 1'b0;
         o_major_alarm    <= 1'b0;
         o_minor_alarm    <= 1'b0;
      end else begin
         o_card_fail_lamp <= i_card_circuit_fault | i_io_circuit_fault;
         o_major_alarm    <= major_now;
         o_minor_alarm    <= minor_now;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);

   sequence carrier_held_s;
      (i_loss_of_carrier[0] && i_io_module_present && !i_download_active) [*3];
   endsequence

   // four cycles: a lit blink bit still drains through blink_q and bottom_q
   sequence dead_s;
      !alive_q [*4];
   endsequence

   lamp_follow_a: assert property ((i_card_circuit_fault || i_io_circuit_fault)
      |=> o_card_fail_lamp) else $error("fail lamp not lit");
   major_flag_a: assert property (o_major_alarm == $past(|i_loss_of_carrier))
      else $error("major flag wrong");
   minor_flag_a: assert property ((|i_slip_threshold || |i_out_of_service_state)
      |=> o_minor_alarm) else $error("minor flag missing");
   red_wins_a: assert property ((|i_loss_of_carrier && i_io_module_present
      && !i_download_active) |=> sel_q == GLYPH_RED) else $error("major not shown");
   minor_over_info_a: assert property ((minor_now && !major_now && i_maintenance
      && i_io_module_present && !i_download_active) |=> sel_q != GLYPH_MAINT)
      else $error("maintenance hid an alarm");
   group_mark_a: assert property (carrier_held_s |-> o_dots[COLS-1])
      else $error("group one dot dark");
   spin_shown_a: assert property (i_download_active |=> sel_q inside
      {GLYPH_SPIN0, GLYPH_SPIN1, GLYPH_SPIN2, GLYPH_SPIN3})
      else $error("download meter missing");
   no_io_shown_a: assert property ((!i_io_module_present && !i_download_active)
      |=> sel_q == GLYPH_NO_IO) else $error("no module not shown");
   beat_alive_a: assert property ((i_heartbeat && i_hb_timeout_ms != 16'h0000)
      |=> alive_q) else $error("heartbeat ignored");
   dot_steady_a: assert property (dead_s |-> $stable(o_dots[0]))
      else $error("dot blinks while dead");

endmodule

// ---- sim/tb.sv ----
`timescale 1ns/100ps
module tb;
   import span_display_pkg::*;
   // ------------------------------------------------------------------
   // stimulus and design
   // ------------------------------------------------------------------
   logic        i_core_clk = 1'b0;
   logic        i_reset_n  = 1'b0;
   logic [15:0] loc, lrc, blu, slp, oft, ofr, sbe, svc, hb_to;
   logic        e1, mnt, iop, dl, hb, cflt, iflt;
   logic [34:0] dots;
   logic        lamp, major, minor, alive;
   int          err_count = 0;
   int          compares  = 0;
   logic [29:0] top [13];
   logic [29:0] spin [5];
   int          tgl;
   logic        prev_dot;

   always #10 i_core_clk = ~i_core_clk;

   span_alarm_status_display #(.TICK_CYCLES(4)) span_alarm_status_display_i (
      .i_core_clk              (i_core_clk),
      .i_reset_n               (i_reset_n),
      .i_loss_of_carrier       (loc),
      .i_loss_remote_carrier   (lrc),
      .i_blue_alarm            (blu),
      .i_slip_threshold        (slp),
      .i_out_of_frame_threshold(oft),
      .i_out_of_frame          (ofr),
      .i_signaling_bit_error   (sbe),
      .i_out_of_service_state  (svc),
      .i_card_is_e1            (e1),
      .i_maintenance           (mnt),
      .i_io_module_present     (iop),
      .i_download_active       (dl),
      .i_heartbeat             (hb),
      .i_hb_timeout_ms         (hb_to),
      .i_card_circuit_fault    (cflt),
      .i_io_circuit_fault      (iflt),
      .o_dots                  (dots),
      .o_card_fail_lamp        (lamp),
      .o_major_alarm           (major),
      .o_minor_alarm           (minor),
      .o_cpu_alive             (alive)
   );

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // every drive and every sample lands 2 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
      #2;
   endtask

   task automatic chk(input logic [34:0] got, input logic [34:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
         err_count++;
      end
   endtask

   task automatic chk_ne(input logic [29:0] a, input logic [29:0] b, input string msg);
      compares++;
      if (a === b) begin
         $display("BAD %0t %s patterns equal", $time, msg);
         err_count++;
      end
   endtask

   task automatic clear_all();
      {loc, lrc, blu, slp, oft, ofr, sbe, svc} = '0;
      {e1, mnt, dl, hb, cflt, iflt} = '0;
      iop = 1'b1;
   endtask

   // codes 0..8 rise in severity; 10..12 are the other framing causes
   task automatic apply(input int c, input int s);
      case (c)
         1: e1 = 1'b1;
         2: mnt = 1'b1;
         3: svc[s] = 1'b1;
         4: slp[s] = 1'b1;
         5: blu[s] = 1'b1;
         6: lrc[s] = 1'b1;
         7: loc[s] = 1'b1;
         8: iop = 1'b0;
         9: dl = 1'b1;
         10: oft[s] = 1'b1;
         11: ofr[s] = 1'b1;
         12: sbe[s] = 1'b1;
         default: ;
      endcase
   endtask

   function automatic logic [4:0] grp(input int c, input int s);
      if ((c >= 3 && c <= 7) || c >= 10)
         return 5'h10 >> (s / 4);
      return 5'h00;
   endfunction

   task automatic beat();
      hb = 1'b1;
      tick(1);
      hb = 1'b0;
   endtask

   task automatic results();
      if (err_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------
   initial begin
      clear_all();
      hb_to = 16'h0000;
      tick(3);
      chk(35'(dots), 35'h0, "matrix dark in reset");
      chk(35'({lamp, major, minor, alive}), 35'h0, "flags low in reset");
      i_reset_n = 1'b1;
      tick(3);
      for (int c = 0; c <= 12; c++) begin
         if (c == 9)
            continue;
         apply(c, c);
         tick(3);
         top[c] = dots[34:5];
         if (c >= 10)
            chk(35'(top[c]), 35'(top[4]), "framing causes share glyph");
         chk(35'(dots[4:0]), 35'(grp(c, c)), "group dots");
         chk(35'(major), 35'(c == 7), "major class");
         chk(35'(minor), 35'((c >= 3 && c <= 6) || c >= 10), "minor class");
         chk(35'(lamp), 35'h0, "lamp without fault");
         clear_all();
         tick(1);
      end
      for (int i = 0; i < 9; i++)
         for (int j = i + 1; j < 9; j++)
            chk_ne(top[i], top[j], "glyphs distinct");
      clear_all();
      for (int c = 1; c <= 8; c++) begin
         apply(c, c);
         tick(3);
         chk(35'(dots[34:5]), 35'(top[c]), "most severe shown");
         chk(35'(dots[4:0]), 35'(grp(c, c)), "only its groups");
      end
      clear_all();
      tick(1);
      for (int s = 0; s < 16; s++) begin
         apply(7, s);
         tick(3);
         chk(35'(dots[4:0]), 35'(5'h10 >> (s / 4)), "group of span");
         clear_all();
         tick(1);
      end
      cflt = 1'b1;
      tick(2);
      chk(35'(lamp), 35'h1, "card fault lamp");
      cflt = 1'b0;
      iflt = 1'b1;
      tick(2);
      chk(35'(lamp), 35'h1, "module fault lamp");
      iflt = 1'b0;
      beat();
      tick(3);
      chk(35'(alive), 35'h0, "zero timeout never alive");
      // 1000 ms with 4-cycle ticks: 4000 cycles, 250 ms half blink is 1000
      hb_to = 16'h03e8;
      beat();
      tick(1);
      chk(35'(alive), 35'h1, "alive after beat");
      tgl = 0;
      prev_dot = dots[0];
      for (int k = 0; k < 2200; k++) begin
         if (k % 500 == 499)
            hb = 1'b1;
         else
            hb = 1'b0;
         tick(1);
         if (dots[0] !== prev_dot)
            tgl++;
         prev_dot = dots[0];
      end
      hb = 1'b0;
      chk(35'(tgl), 35'h2, "blink while alive");
      tick(4100);
      chk(35'({alive, dots[0]}), 35'h0, "dead after timeout");
      tgl = 0;
      repeat (1100) begin
         tick(1);
         if (dots[0] !== 1'b0)
            tgl++;
      end
      chk(35'(tgl), 35'h0, "dot steady when dead");
      apply(9, 0);
      tick(200);
      for (int k = 0; k < 5; k++) begin
         spin[k] = dots[34:5];
         chk(35'(dots[4:0]), 35'h0, "no group dots on download");
         tick(400);
      end
      for (int i = 0; i < 4; i++)
         for (int j = i + 1; j < 4; j++)
            chk_ne(spin[i], spin[j], "meter steps differ");
      chk(35'(spin[4]), 35'(spin[0]), "meter wraps after four steps");
      results();
   end

   initial begin
      repeat (30000) @(posedge i_core_clk);
      err_count++;
      results();
   end
endmodule
